// file: rtl/fbps_defs.svh
/*
  Constants of the full-bridge phase sequencer: timing, soft-start levels and widths.
  Assumes a 20 MHz core clock; included by bare name from the rtl folder.
*/
// What this block does
// - Drive the diagonal high_side_drive_a with low_side_drive_b, then all off, then high_side_drive_b with low_side_drive_a, then all off, and repeat.
// - Swap diagonals on every oscillator cycle so each phase output runs at half the oscillator rate.
// - Keep a fixed internal dead-time between phases that does not depend on frequency, even with zero lead dead-time.
// - Limit each phase's duty to the oscillator period minus the lead dead-time, over twice the period.
// - With the loop error input open, run at the maximum allowed duty.
// - End each pulse when the ramp rises above the lower of the soft-start level and the loop error level.
// - Hold soft-start at zero after power-up, ramp it once line, supply and reference are good, and let it steer duty only above an offset.
// - When soft-start is forced low the duty collapses to zero, and release starts a new soft-start ramp.
// - End the pulse at once when the current-sense trip input is high.
// - While the first diagonal carries power, assert rectifier_ctrl_a and deassert rectifier_ctrl_b.
// - While the second diagonal carries power, assert rectifier_ctrl_b and deassert rectifier_ctrl_a.
// - In the freewheel gap between power pulses assert both rectifier controls.
// - Drop the rectifier out of phase with the coming pulse ahead of it by the lead dead-time.
// - Lead and trail dead-times are set independently as setting resistance times 3 pF over 20k to 100k; only the lead one cuts duty.
`ifndef FBPS_DEFS_SVH
`define FBPS_DEFS_SVH

`define FBPS_CLK_PERIOD_NS  50
`define FBPS_INT_DT_NS      30
`define FBPS_INT_DT_CYC     (((`FBPS_INT_DT_NS + `FBPS_CLK_PERIOD_NS - 1) / `FBPS_CLK_PERIOD_NS) < 1 ? 1 : ((`FBPS_INT_DT_NS + `FBPS_CLK_PERIOD_NS - 1) / `FBPS_CLK_PERIOD_NS))
`define FBPS_DT_CAP_PF      3
`define FBPS_RD_MIN_KOHM    20
`define FBPS_RD_MAX_KOHM    100
`define FBPS_LVL_W          10
`define FBPS_SS_OFFSET      10'h0cd
`define FBPS_SS_MAX         10'h3ff
`define FBPS_SS_STEP_CYC    8'h10
`define FBPS_CNT_W          16
`define FBPS_SET_W          7

`endif

// file: rtl/fbps_pkg.sv
/*
  Types of the full-bridge phase sequencer.
  Assumes fbps_defs.svh sits beside it.
*/
`include "fbps_defs.svh"
package fbps_pkg;
  typedef logic [`FBPS_LVL_W-1:0] fbps_lvl_t;
  typedef logic [`FBPS_CNT_W-1:0] fbps_cnt_t;
  typedef enum logic {FBPS_DIAG_A, FBPS_DIAG_B} fbps_diag_e;
  typedef enum logic [1:0] {FBPS_HOLD, FBPS_GAP, FBPS_PULSE} fbps_state_e;
endpackage

// file: rtl/fbps_ss_if.sv
/*
  Soft-start carrier between the sequencer and its soft-start ramp.
  Assumes one core clock for both ends.
*/
`timescale 1ns/1ps
interface fbps_ss_if;
  logic              bias_ok;
  logic              force_low;
  fbps_pkg::fbps_lvl_t level;
  fbps_pkg::fbps_lvl_t eff;
  logic              released;
  modport ramp (input bias_ok, input force_low, output level, output eff, output released);
  modport seq  (output bias_ok, output force_low, input level, input eff, input released);
endinterface

// file: rtl/fbps_softstart.sv
/*
  Soft-start ramp: held at zero until bias is good, then rises one step per interval.
  Assumes inputs synchronous to the core clock.
*/
`timescale 1ns/1ps
`include "fbps_defs.svh"
module fbps_softstart (
  input wire logic clk,
  input wire logic rstn,
  fbps_ss_if.ramp  ss
);
  fbps_pkg::fbps_lvl_t level_r;
  logic [7:0]          step_r;
  logic                hold;

  assign hold = !ss.bias_ok || ss.force_low;

  // a forced-low pin discharges at once; release restarts from zero
  always_ff @(posedge clk) begin
    if (!rstn || hold) begin
      level_r <= '0;
      step_r  <= 8'h00;
    end else if (step_r == `FBPS_SS_STEP_CYC - 8'h01) begin
      step_r  <= 8'h00;
      if (level_r != `FBPS_SS_MAX)
        level_r <= level_r + 10'h001;
    end else begin
      step_r <= step_r + 8'h01;
    end
  end

  assign ss.level    = level_r;
  assign ss.released = !hold;
  // below the offset soft-start allows no duty at all
  assign ss.eff      = (level_r > `FBPS_SS_OFFSET) ? level_r - `FBPS_SS_OFFSET : '0;
endmodule

// file: rtl/fbps_dt_timer.sv
/*
  One-shot dead-time timer: loaded with a cycle count, pulses done when it runs out.
  Assumes load is a single-cycle pulse; a new load restarts it.
*/
`timescale 1ns/1ps
`include "fbps_defs.svh"
module fbps_dt_timer (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic                  load,
  input  wire logic [`FBPS_CNT_W-1:0] cycles,
  input  wire logic                  cancel,
  output logic                       done
);
  logic [`FBPS_CNT_W-1:0] cnt_r;
  logic                   busy_r;

  always_ff @(posedge clk) begin
    if (!rstn || cancel) begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
    end else if (load) begin
      cnt_r  <= cycles;
      busy_r <= 1'b1;
    end else if (busy_r) begin
      if (cnt_r <= 16'h0001)
        busy_r <= 1'b0;
      cnt_r <= cnt_r - 16'h0001;
    end
  end

  assign done = busy_r && (cnt_r <= 16'h0001) && !load;
endmodule

// file: rtl/fbps_top.sv
/*
  Full-bridge phase sequencer: alternates the two bridge diagonals on each oscillator
  tick, limits duty by the lead dead-time, gates pulses with soft-start, loop error and
  current trip, and sequences the two synchronous-rectifier controls.
  Assumes OSC_TICK is a one-cycle pulse per oscillator cycle, comparator levels are
  digital codes on the same scale, and all inputs are synchronous to CORE_CLK.
*/
`timescale 1ns/1ps
`include "fbps_defs.svh"
module fbps_top (
  input  wire logic                   CORE_CLK,
  input  wire logic                   RSTN,
  input  wire logic                   OSC_TICK,
  input  wire logic                   LINE_UNDERVOLTAGE_OK,
  input  wire logic                   VCC_OK,
  input  wire logic                   REF_OK,
  input  wire logic                   SS_FORCE_LOW,
  input  wire logic                   CS_TRIP,
  input  wire logic                   LOOP_ERR_OPEN,
  input  wire logic [`FBPS_LVL_W-1:0] RAMP_LEVEL,
  input  wire logic [`FBPS_LVL_W-1:0] LOOP_ERR_LEVEL,
  input  wire logic [`FBPS_SET_W-1:0] LEAD_DEADTIME_SETTING,
  input  wire logic [`FBPS_SET_W-1:0] TRAIL_DEADTIME_SETTING,
  output logic                        HIGH_SIDE_DRIVE_A,
  output logic                        HIGH_SIDE_DRIVE_B,
  output logic                        LOW_SIDE_DRIVE_A,
  output logic                        LOW_SIDE_DRIVE_B,
  output logic                        RECTIFIER_CTRL_A,
  output logic                        RECTIFIER_CTRL_B,
  output logic                        SS_ACTIVE
);

  // setting in kilohms to dead-time cycles: t = R * 3 pF, rounded up,
  // clamped to the usable resistor range and never under the internal dead-time
  function automatic fbps_pkg::fbps_cnt_t dt_cycles(input logic [`FBPS_SET_W-1:0] kohm);
    logic [`FBPS_SET_W-1:0] r;
    fbps_pkg::fbps_cnt_t    c;
    r = kohm;
    if (r < 7'(`FBPS_RD_MIN_KOHM))
      r = 7'(`FBPS_RD_MIN_KOHM);
    if (r > 7'(`FBPS_RD_MAX_KOHM))
      r = 7'(`FBPS_RD_MAX_KOHM);
    c = 16'((32'(r) * `FBPS_DT_CAP_PF + `FBPS_CLK_PERIOD_NS - 1) / `FBPS_CLK_PERIOD_NS);
    if (c < 16'(`FBPS_INT_DT_CYC))
      c = 16'(`FBPS_INT_DT_CYC);
    return c;
  endfunction

  function automatic fbps_pkg::fbps_lvl_t lower_of(input fbps_pkg::fbps_lvl_t a,
                                                   input fbps_pkg::fbps_lvl_t b);
    return (a < b) ? a : b;
  endfunction

  fbps_ss_if ss ();

  fbps_pkg::fbps_state_e state_r;
  fbps_pkg::fbps_diag_e  next_diag_r;
  fbps_pkg::fbps_diag_e  cur_diag_r;
  fbps_pkg::fbps_cnt_t   cyc_r;
  fbps_pkg::fbps_cnt_t   period_r;
  fbps_pkg::fbps_cnt_t   lead_cyc;
  fbps_pkg::fbps_cnt_t   trail_cyc;
  fbps_pkg::fbps_cnt_t   end_cnt;
  fbps_pkg::fbps_lvl_t   duty_limit;
  logic                  bias_ok;
  logic                  period_ok;
  logic                  at_lead;
  logic                  terminate;
  logic                  start_ok;
  logic                  pulse_end;
  logic                  lead_passed_r;
  logic                  trail_done;

  assign bias_ok      = LINE_UNDERVOLTAGE_OK && VCC_OK && REF_OK;
  assign ss.bias_ok   = bias_ok;
  assign ss.force_low = SS_FORCE_LOW;

  fbps_softstart u_softstart (
    .clk  (CORE_CLK),
    .rstn (RSTN),
    .ss   (ss.ramp)
  );

  assign lead_cyc  = dt_cycles(LEAD_DEADTIME_SETTING);
  assign trail_cyc = dt_cycles(TRAIL_DEADTIME_SETTING);

  // oscillator period measured in core cycles, refreshed at every tick
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      cyc_r    <= '0;
      period_r <= '0;
    end else if (OSC_TICK) begin
      cyc_r    <= '0;
      period_r <= cyc_r + 16'h0001;
    end else if (cyc_r != 16'hffff) begin
      cyc_r <= cyc_r + 16'h0001;
    end
  end

  // the pulse must be gone lead dead-time cycles before the next tick; this is the
  // only place the lead setting touches duty, the trail setting never does
  assign period_ok = period_r > lead_cyc + 16'h0001;
  assign end_cnt   = period_ok ? period_r - lead_cyc : '0;
  assign at_lead   = period_ok && (cyc_r + 16'h0001 == end_cnt);

  // open loop error input leaves only soft-start in charge, which gives full duty
  assign duty_limit = LOOP_ERR_OPEN ? ss.eff
                    : lower_of(ss.eff, LOOP_ERR_LEVEL);

  assign terminate = CS_TRIP
                  || (RAMP_LEVEL > duty_limit)
                  || (cyc_r + 16'h0001 >= end_cnt);

  assign start_ok = OSC_TICK && period_ok && ss.released
                 && (duty_limit != '0) && !CS_TRIP;

  assign pulse_end = (state_r == fbps_pkg::FBPS_PULSE) && terminate;

  // phase sequencing and bridge drivers
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN || !bias_ok) begin
      state_r           <= fbps_pkg::FBPS_HOLD;
      next_diag_r       <= fbps_pkg::FBPS_DIAG_A;
      cur_diag_r        <= fbps_pkg::FBPS_DIAG_A;
      HIGH_SIDE_DRIVE_A <= 1'b0;
      HIGH_SIDE_DRIVE_B <= 1'b0;
      LOW_SIDE_DRIVE_A  <= 1'b0;
      LOW_SIDE_DRIVE_B  <= 1'b0;
    end else begin
      // the diagonal alternates on every tick, pulse or not
      if (OSC_TICK)
        next_diag_r <= (next_diag_r == fbps_pkg::FBPS_DIAG_A) ?
                       fbps_pkg::FBPS_DIAG_B : fbps_pkg::FBPS_DIAG_A;
      case (state_r)
        fbps_pkg::FBPS_HOLD: begin
          state_r <= fbps_pkg::FBPS_GAP;
        end
        fbps_pkg::FBPS_GAP: begin
          // the gap always spans at least the lead dead-time, so a tick start is safe
          if (start_ok) begin
            state_r    <= fbps_pkg::FBPS_PULSE;
            cur_diag_r <= next_diag_r;
            if (next_diag_r == fbps_pkg::FBPS_DIAG_A) begin
              HIGH_SIDE_DRIVE_A <= 1'b1;
              LOW_SIDE_DRIVE_B  <= 1'b1;
            end else begin
              HIGH_SIDE_DRIVE_B <= 1'b1;
              LOW_SIDE_DRIVE_A  <= 1'b1;
            end
          end
        end
        fbps_pkg::FBPS_PULSE: begin
          if (terminate || SS_FORCE_LOW) begin
            state_r           <= fbps_pkg::FBPS_GAP;
            HIGH_SIDE_DRIVE_A <= 1'b0;
            HIGH_SIDE_DRIVE_B <= 1'b0;
            LOW_SIDE_DRIVE_A  <= 1'b0;
            LOW_SIDE_DRIVE_B  <= 1'b0;
          end
        end
        default: begin
          state_r           <= fbps_pkg::FBPS_HOLD;
          HIGH_SIDE_DRIVE_A <= 1'b0;
          HIGH_SIDE_DRIVE_B <= 1'b0;
          LOW_SIDE_DRIVE_A  <= 1'b0;
          LOW_SIDE_DRIVE_B  <= 1'b0;
        end
      endcase
    end
  end

  // trail dead-time runs from the end of each pulse; a new tick cancels a stale count
  fbps_dt_timer u_trail (
    .clk    (CORE_CLK),
    .rstn   (RSTN),
    .load   (pulse_end || ((state_r == fbps_pkg::FBPS_PULSE) && SS_FORCE_LOW)),
    .cycles (trail_cyc),
    .cancel (OSC_TICK || !bias_ok),
    .done   (trail_done)
  );

  // once the lead point of a cycle passes, a late trail expiry must not turn the
  // out-of-phase rectifier back on ahead of the coming pulse
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN || !bias_ok || OSC_TICK)
      lead_passed_r <= 1'b0;
    else if (at_lead)
      lead_passed_r <= 1'b1;
  end

  // rectifier controls; held low only while soft-start is held by low bias or a forced-low pin,
  // so they engage from the first tick after release, before any primary pulses
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN || !bias_ok || !ss.released) begin
      RECTIFIER_CTRL_A <= 1'b0;
      RECTIFIER_CTRL_B <= 1'b0;
    end else if ((state_r == fbps_pkg::FBPS_GAP) && start_ok) begin
      if (next_diag_r == fbps_pkg::FBPS_DIAG_A) begin
        RECTIFIER_CTRL_A <= 1'b1;
        RECTIFIER_CTRL_B <= 1'b0;
      end else begin
        RECTIFIER_CTRL_A <= 1'b0;
        RECTIFIER_CTRL_B <= 1'b1;
      end
    end else if (at_lead) begin
      // drop the rectifier that opposes the diagonal due at the next tick; at full
      // duty this is the edge the pulse ends, so the in-phase one falls with it
      if (next_diag_r == fbps_pkg::FBPS_DIAG_A)
        RECTIFIER_CTRL_B <= 1'b0;
      else
        RECTIFIER_CTRL_A <= 1'b0;
    end else if (trail_done && !lead_passed_r && (state_r == fbps_pkg::FBPS_GAP)) begin
      RECTIFIER_CTRL_A <= 1'b1;
      RECTIFIER_CTRL_B <= 1'b1;
    end else if ((state_r == fbps_pkg::FBPS_GAP) && OSC_TICK
                 && !RECTIFIER_CTRL_A && !RECTIFIER_CTRL_B) begin
      // a skipped cycle that opens with both rectifiers off still freewheels through both
      RECTIFIER_CTRL_A <= 1'b1;
      RECTIFIER_CTRL_B <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN)
      SS_ACTIVE <= 1'b0;
    else
      SS_ACTIVE <= ss.released && (ss.eff != '0);
  end

endmodule

// file: tb/fbps_bridge_model.sv
/*
  Far side of the sequencer: the four bridge gates, counting power pulses
  and latching any leg shoot-through. Assumes registered gate levels.
*/
`timescale 1ns/1ps
module fbps_bridge_model (
  input  wire logic        clk,
  input  wire logic        hi_a,
  input  wire logic        hi_b,
  input  wire logic        lo_a,
  input  wire logic        lo_b,
  output logic      [15:0] pulses = 16'h0,
  output logic             shoot  = 1'b0
);
  logic was_on = 1'b0;
  always @(posedge clk) begin
    was_on <= hi_a | hi_b;
    if ((hi_a | hi_b) & ~was_on)
      pulses <= pulses + 16'h1;
    // both switches of one leg on would short the input rail
    if ((hi_a & lo_a) | (hi_b & lo_b))
      shoot <= 1'b1;
  end
endmodule

// file: tb/fbps_monitor.sv
/*
  Port checker of the phase sequencer. Assumes one clock and sync reset.
*/
`timescale 1ns/1ps
module fbps_monitor (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic OSC_TICK,
  input wire logic LINE_UNDERVOLTAGE_OK,
  input wire logic SS_FORCE_LOW,
  input wire logic CS_TRIP,
  input wire logic HIGH_SIDE_DRIVE_A,
  input wire logic HIGH_SIDE_DRIVE_B,
  input wire logic LOW_SIDE_DRIVE_A,
  input wire logic LOW_SIDE_DRIVE_B,
  input wire logic RECTIFIER_CTRL_A,
  input wire logic RECTIFIER_CTRL_B,
  input wire logic SS_ACTIVE
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  logic any_on;
  assign any_on = HIGH_SIDE_DRIVE_A | HIGH_SIDE_DRIVE_B;
  property p_diag_a; HIGH_SIDE_DRIVE_A == LOW_SIDE_DRIVE_B; endproperty
  a_diag_a: assert property (p_diag_a) else $error("diagonal a legs differ");
  property p_diag_b; HIGH_SIDE_DRIVE_B == LOW_SIDE_DRIVE_A; endproperty
  a_diag_b: assert property (p_diag_b) else $error("diagonal b legs differ");
  property p_overlap; !(HIGH_SIDE_DRIVE_A && HIGH_SIDE_DRIVE_B); endproperty
  a_overlap: assert property (p_overlap) else $error("both diagonals on");
  property p_bias; !LINE_UNDERVOLTAGE_OK |=> !(any_on | RECTIFIER_CTRL_A | RECTIFIER_CTRL_B | SS_ACTIVE); endproperty
  a_bias: assert property (p_bias) else $error("outputs live with bias low");
  property p_rect_a; HIGH_SIDE_DRIVE_A |-> RECTIFIER_CTRL_A && !RECTIFIER_CTRL_B; endproperty
  a_rect_a: assert property (p_rect_a) else $error("rectifiers wrong in a pulse");
  property p_rect_b; HIGH_SIDE_DRIVE_B |-> RECTIFIER_CTRL_B && !RECTIFIER_CTRL_A; endproperty
  a_rect_b: assert property (p_rect_b) else $error("rectifiers wrong in b pulse");
  property p_trip; CS_TRIP && any_on |=> !any_on; endproperty
  a_trip: assert property (p_trip) else $error("pulse outlived current trip");
  property p_force; SS_FORCE_LOW [*2] |-> !any_on; endproperty
  a_force: assert property (p_force) else $error("pulse while soft-start forced");
  property p_start; $rose(any_on) |-> $past(OSC_TICK); endproperty
  a_start: assert property (p_start) else $error("pulse began off the tick");
  property p_lead_a; $rose(HIGH_SIDE_DRIVE_A) |-> !$past(RECTIFIER_CTRL_B); endproperty
  a_lead_a: assert property (p_lead_a) else $error("rectifier b on ahead of a pulse");
  property p_lead_b; $rose(HIGH_SIDE_DRIVE_B) |-> !$past(RECTIFIER_CTRL_A); endproperty
  a_lead_b: assert property (p_lead_b) else $error("rectifier a on ahead of b pulse");
endmodule
bind fbps_top fbps_monitor mon (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .OSC_TICK(OSC_TICK),
  .LINE_UNDERVOLTAGE_OK(LINE_UNDERVOLTAGE_OK), .SS_FORCE_LOW(SS_FORCE_LOW), .CS_TRIP(CS_TRIP),
  .HIGH_SIDE_DRIVE_A(HIGH_SIDE_DRIVE_A), .HIGH_SIDE_DRIVE_B(HIGH_SIDE_DRIVE_B),
  .LOW_SIDE_DRIVE_A(LOW_SIDE_DRIVE_A), .LOW_SIDE_DRIVE_B(LOW_SIDE_DRIVE_B),
  .RECTIFIER_CTRL_A(RECTIFIER_CTRL_A), .RECTIFIER_CTRL_B(RECTIFIER_CTRL_B), .SS_ACTIVE(SS_ACTIVE));

// file: tb/fbps_top_bench.sv
/*
  Self-checking bench of the phase sequencer: dead-time rows, then trip,
  forced soft-start and bias loss. Assumes the bridge model and checker.
*/
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
  $display("BAD %s exp %0d got %0d", n, e, a); end end
module fbps_top_bench;
  typedef struct {int ls; int ts; logic op; int lvl; int w;} fbps_row_s;
  logic       core_clk = 1'b0, rstn = 1'b0, osc_tick = 1'b0;
  logic [2:0] bias     = 3'h7;
  logic       ss_force = 1'b0, cs_trip = 1'b0, err_open = 1'b1, shoot;
  logic [9:0] ramp     = 10'h0, err_lvl = 10'h3ff;
  logic [6:0] lead_set = 7'h14, trail_set = 7'h14;
  logic       ha, hb, la, lb, ra, rb, ss_act;
  logic [15:0] npulse;
  int         per = 40, cnt = 0, cyc = 0, mismatches = 0, checks_done = 0;
  int         w, fw, gap, base, e;
  // w = 0 marks rows whose pulse is cut by the loop error level
  fbps_row_s  rows[5] = '{'{20, 20, 1, 1023, 38}, '{100, 20, 1, 1023, 34},
                          '{60, 100, 1, 1023, 36}, '{20, 100, 0, 12, 0}, '{100, 20, 0, 12, 0}};
  fbps_top dut (.CORE_CLK(core_clk), .RSTN(rstn), .OSC_TICK(osc_tick),
    .LINE_UNDERVOLTAGE_OK(bias[0]), .VCC_OK(bias[1]), .REF_OK(bias[2]), .SS_FORCE_LOW(ss_force),
    .CS_TRIP(cs_trip), .LOOP_ERR_OPEN(err_open), .RAMP_LEVEL(ramp), .LOOP_ERR_LEVEL(err_lvl),
    .LEAD_DEADTIME_SETTING(lead_set), .TRAIL_DEADTIME_SETTING(trail_set),
    .HIGH_SIDE_DRIVE_A(ha), .HIGH_SIDE_DRIVE_B(hb), .LOW_SIDE_DRIVE_A(la),
    .LOW_SIDE_DRIVE_B(lb), .RECTIFIER_CTRL_A(ra), .RECTIFIER_CTRL_B(rb), .SS_ACTIVE(ss_act));
  fbps_bridge_model far (.clk(core_clk), .hi_a(ha), .hi_b(hb), .lo_a(la), .lo_b(lb),
    .pulses(npulse), .shoot(shoot));
  always #25 core_clk = ~core_clk;
  // ramp restarts each oscillator cycle, like a sensed primary current
  always @(negedge core_clk) begin
    cyc <= cyc + 1;
    cnt = (cnt + 1) % per;
    osc_tick <= (cnt == 0);
    ramp <= 10'(cnt);
    if (cyc == 30000) begin
      mismatches++;
      stop_test();
    end
  end
  function automatic int dt(input int r);
    return (r * 3 + 49) / 50;
  endfunction
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task until_a;
    int g;
    g = 0;
    while (ha !== 1'b1 && g < 200) begin
      @(negedge core_clk);
      g++;
    end
  endtask
  task meas;
    until_a();
    base = cyc;
    w = 0;
    fw = 0;
    while (ha === 1'b1) begin
      w++;
      @(negedge core_clk);
    end
    while (hb !== 1'b1 && cyc - base < 200) begin
      fw += int'(ra & rb);
      @(negedge core_clk);
    end
    gap = cyc - base;
  endtask
  task wait_ss;
    int g;
    g = 0;
    while (ss_act !== 1'b1 && g < 4000) begin
      @(negedge core_clk);
      g++;
    end
    `CHK("ss_up", 1'b1, ss_act)
  endtask
  initial begin
    repeat (5) @(negedge core_clk);
    `CHK("reset", 7'h0, {ha, hb, la, lb, ra, rb, ss_act})
    rstn = 1'b1;
    repeat (3000) @(negedge core_clk);
    `CHK("early", 17'h0, {ss_act, npulse})
    wait_ss();
    repeat (1000) @(negedge core_clk);
    foreach (rows[i]) begin
      lead_set = 7'(rows[i].ls);
      trail_set = 7'(rows[i].ts);
      err_open = rows[i].op;
      err_lvl = 10'(rows[i].lvl);
      meas();
      meas();
      `CHK("period", 2 * per / 2, gap)
      if (rows[i].w != 0)
        `CHK("width", rows[i].w, w)
      else
        `CHK("short", 1'b1, w < per - dt(rows[i].ls))
      e = per - w - dt(rows[i].ts) - dt(rows[i].ls);
      `CHK("freewheel", (e < 0) ? 0 : e, fw)
    end
    err_open = 1'b1;
    until_a();
    repeat (3) @(negedge core_clk);
    cs_trip = 1'b1;
    @(negedge core_clk);
    `CHK("trip", 1'b0, ha)
    cs_trip = 1'b0;
    ss_force = 1'b1;
    repeat (2) @(negedge core_clk);
    base = npulse;
    repeat (200) @(negedge core_clk);
    `CHK("forced", 17'(base), {ss_act, npulse})
    ss_force = 1'b0;
    repeat (100) @(negedge core_clk);
    `CHK("restart", 1'b0, ss_act)
    wait_ss();
    // each of line, supply and reference must hold the block off on its own
    for (int k = 0; k < 3; k++) begin
      bias[k] = 1'b0;
      repeat (2) @(negedge core_clk);
      `CHK("bias", 7'h0, {ha, hb, la, lb, ra, rb, ss_act})
      bias[k] = 1'b1;
      wait_ss();
    end
    `CHK("shoot", 1'b0, shoot)
    stop_test();
  end
endmodule
